// [verilog/nsm_send_mailbox.sv]
// send mailbox handshake with start-up parameters and receive path
`timescale 1ns/1ps
module nsm_send_mailbox (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_we_i,
  input  wire logic       reg_re_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       run_i,
  output logic            tx_valid_o,
  output logic      [7:0] tx_data_o,
  output logic            tx_last_o,
  output logic            tx_express_o,
  input  wire logic       tx_ready_i,
  input  wire logic       tx_done_i,
  input  wire logic       tx_fail_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_last_i,
  input  wire logic       rx_express_i,
  output logic            rx_wr_o,
  output nsm_pkg::nsm_idx_t rx_wr_idx_o,
  output logic      [7:0] rx_wr_data_o,
  output logic      [7:0] station_o,
  output logic      [7:0] pgn_o,
  output logic            irq_o
);
  import nsm_pkg::*;

  // true when the address falls in the send mailbox window
  function automatic logic is_mbox(input logic [7:0] a);
    return a[7] && (a[6:0] <= MBOX_LAST_IDX);
  endfunction

  nsm_mem_if mem_bus ();

  nsm_tx_state_t st_q;
  nsm_tx_state_t st_d;
  logic          busy_q;
  logic          err_q;
  logic          expr_q;
  logic [7:0]    len_q;
  logic [7:0]    dest_q;
  nsm_idx_t      ptr_q;
  logic          tx_valid_q;
  logic [7:0]    tx_data_q;
  logic          tx_last_q;
  logic          tx_expr_q;
  logic          rcb_permit_q;
  logic          rcb_expr_q;
  nsm_idx_t      rx_idx_q;
  logic          rx_wr_q;
  nsm_idx_t      rx_wr_idx_q;
  logic [7:0]    rx_wr_data_q;
  logic [IRQ_W-1:0] istat_q;
  logic [IRQ_W-1:0] istat_d;
  logic [IRQ_W-1:0] imask_q;
  logic          irq_q;
  logic [7:0]    rdata_q;
  logic [7:0]    stn_edit_q;
  logic [7:0]    pgn_edit_q;
  logic [7:0]    stn_act_q;
  logic [7:0]    pgn_act_q;
  logic          run_s1_q;
  logic          run_s2_q;
  logic          run_s3_q;
  logic [7:0]    loc_e_rd [12];
  logic [7:0]    loc_a_rd [12];
  logic [7:0]    rd_val;

  // register port decode
  wire wr_scb   = reg_we_i && (reg_addr_i == REG_SCB);
  wire wr_rcb   = reg_we_i && (reg_addr_i == REG_RCB);
  wire wr_imask = reg_we_i && (reg_addr_i == REG_IMASK);
  wire wr_stn   = reg_we_i && (reg_addr_i == REG_STN_EDIT);
  wire wr_pgn   = reg_we_i && (reg_addr_i == REG_PGN_EDIT);
  wire rd_istat = reg_re_i && (reg_addr_i == REG_ISTAT);
  wire wr_mbox  = reg_we_i && is_mbox(reg_addr_i) && !busy_q;
  wire [6:0] mbox_idx = reg_addr_i[6:0];

  // request handling against the captured length and destination
  wire fields_ok = (len_q <= MAX_LEN) && (dest_q <= DEST_MAX);
  wire req_wr    = wr_scb && reg_wdata_i[SCB_BUSY] && !busy_q;
  wire accept    = req_wr && fields_ok;
  wire reject    = req_wr && !fields_ok;
  wire done_evt  = (st_q == ST_WAIT) && tx_done_i;
  wire hs        = tx_valid_q && tx_ready_i;
  wire [6:0] last_idx = len_q[6:0] + 7'h01;
  wire run_rise  = run_s2_q && !run_s3_q;

  // mailbox memory port: software writes, transmitter reads
  assign mem_bus.we    = wr_mbox;
  assign mem_bus.waddr = mbox_idx;
  assign mem_bus.wdata = reg_wdata_i;
  assign mem_bus.raddr = ptr_q;

  nsm_mbox_mem u_mem (
    .clk_sys_i (clk_sys_i),
    .mem_port  (mem_bus.mem)
  );

  // snoop length and destination as software writes them
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      len_q  <= 8'h00;
      dest_q <= 8'h00;
    end else if (wr_mbox && (mbox_idx == IDX_LEN)) begin
      len_q  <= reg_wdata_i;
    end else if (wr_mbox && (mbox_idx == IDX_DEST)) begin
      dest_q <= reg_wdata_i;
    end
  end

  // send coordination byte: busy, express and error bits
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      busy_q <= 1'b0;
      err_q  <= 1'b0;
      expr_q <= 1'b0;
    end else begin
      if (accept) begin
        busy_q <= 1'b1;
      end else if (done_evt) begin
        busy_q <= 1'b0;
      end
      if (accept) begin
        err_q <= 1'b0;
      end else if (reject || (done_evt && tx_fail_i)) begin
        err_q <= 1'b1;
      end
      if (wr_scb && !busy_q) begin
        expr_q <= reg_wdata_i[SCB_EXPR];
      end
    end
  end

  // transmit sequencer next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (accept) begin
          st_d = ST_FETCH;
        end
      end
      ST_FETCH: st_d = ST_LOAD;
      ST_LOAD:  st_d = ST_HOLD;
      ST_HOLD: begin
        if (tx_ready_i) begin
          st_d = (ptr_q == last_idx) ? ST_WAIT : ST_FETCH;
        end
      end
      ST_WAIT: begin
        if (tx_done_i) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // byte pointer walks length, destination, payload
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_q  <= ST_IDLE;
      ptr_q <= IDX_LEN;
    end else begin
      st_q <= st_d;
      if (accept) begin
        ptr_q <= IDX_LEN;
      end else if ((st_q == ST_HOLD) && tx_ready_i) begin
        ptr_q <= ptr_q + 7'h01;
      end
    end
  end

  // link side byte stream with express marking
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tx_valid_q <= 1'b0;
      tx_data_q  <= 8'h00;
      tx_last_q  <= 1'b0;
      tx_expr_q  <= 1'b0;
    end else begin
      if (st_q == ST_LOAD) begin
        tx_valid_q <= 1'b1;
        tx_data_q  <= mem_bus.rdata;
        tx_last_q  <= (ptr_q == last_idx);
      end else if (hs) begin
        tx_valid_q <= 1'b0;
        tx_last_q  <= 1'b0;
      end
      if (accept) begin
        // take the mark from the request itself, expr_q updates this edge
        tx_expr_q <= reg_wdata_i[SCB_EXPR];
      end else if (done_evt) begin
        tx_expr_q <= 1'b0;
      end
    end
  end

  // receive path writes at most one mailbox worth of bytes
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rx_idx_q     <= IDX_LEN;
      rx_wr_q      <= 1'b0;
      rx_wr_idx_q  <= IDX_LEN;
      rx_wr_data_q <= 8'h00;
    end else begin
      rx_wr_q <= 1'b0;
      if (rx_valid_i && rcb_permit_q) begin
        if (rx_idx_q <= MBOX_LAST_IDX) begin
          rx_wr_q      <= 1'b1;
          rx_wr_idx_q  <= rx_idx_q;
          rx_wr_data_q <= rx_data_i;
        end
        if (rx_last_i) begin
          rx_idx_q <= IDX_LEN;
        end else if (rx_idx_q != MBOX_FULL_IDX) begin
          rx_idx_q <= rx_idx_q + 7'h01;
        end
      end
    end
  end

  // receive coordination byte: permit and express received
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rcb_permit_q <= 1'b0;
      rcb_expr_q   <= 1'b0;
    end else if (rx_valid_i && rx_last_i && rcb_permit_q) begin
      rcb_permit_q <= 1'b0;
      rcb_expr_q   <= rx_express_i;
    end else if (wr_rcb) begin
      rcb_permit_q <= reg_wdata_i[RCB_PERMIT];
    end
  end

  // sticky interrupt status, cleared by read, set wins
  wire [IRQ_W-1:0] ev = {rx_valid_i && rx_last_i && rcb_permit_q,
                         reject || (done_evt && tx_fail_i),
                         done_evt};
  assign istat_d = (istat_q & ~{IRQ_W{rd_istat}}) | ev;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      istat_q <= '0;
      imask_q <= '0;
      irq_q   <= 1'b0;
    end else begin
      istat_q <= istat_d;
      irq_q   <= |(istat_d & imask_q);
      if (wr_imask) begin
        imask_q <= reg_wdata_i[IRQ_W-1:0];
      end
    end
  end

  // run input from a pin passes two flip-flops before use
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      run_s1_q <= 1'b0;
      run_s2_q <= 1'b0;
      run_s3_q <= 1'b0;
    end else begin
      run_s1_q <= run_i;
      run_s2_q <= run_s1_q;
      run_s3_q <= run_s2_q;
    end
  end

  // station and programmer numbers, edited then applied on run
  wire stn_ok = (reg_wdata_i >= STN_MIN) && (reg_wdata_i <= STN_MAX);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      stn_edit_q <= STN_RST;
      pgn_edit_q <= PGN_RST;
      stn_act_q  <= STN_RST;
      pgn_act_q  <= PGN_RST;
    end else begin
      if (wr_stn && stn_ok) begin
        stn_edit_q <= reg_wdata_i;
      end
      if (wr_pgn && stn_ok) begin
        pgn_edit_q <= reg_wdata_i;
      end
      if (run_rise) begin
        stn_act_q <= stn_edit_q;
        pgn_act_q <= pgn_edit_q;
      end
    end
  end

  // mailbox and coordination byte locations, one entry each
  for (genvar i = 0; i < LOC_N; i++) begin : g_loc
    localparam logic [7:0] A_K = REG_LOC_EDIT + 8'(3 * i);
    localparam logic [7:0] A_B = REG_LOC_EDIT + 8'(3 * i + 1);
    localparam logic [7:0] A_W = REG_LOC_EDIT + 8'(3 * i + 2);
    localparam logic       HI  = (i >= LOC_SCB);
    logic       kind_e_q;
    logic [7:0] blk_e_q;
    logic [7:0] wrd_e_q;
    logic       kind_a_q;
    logic [7:0] blk_a_q;
    logic [7:0] wrd_a_q;
    wire wk = reg_we_i && (reg_addr_i == A_K);
    wire wb = reg_we_i && (reg_addr_i == A_B);
    wire ww = reg_we_i && (reg_addr_i == A_W);
    wire k_ok = !reg_wdata_i[0] || (blk_e_q >= BLK_MIN);
    wire b_ok = (kind_e_q == KIND_FLAG) || (reg_wdata_i >= BLK_MIN);

    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        kind_e_q <= LOC_KIND_RST[i];
        blk_e_q  <= LOC_BLK_RST[8*i +: 8];
        wrd_e_q  <= LOC_WRD_RST[8*i +: 8];
        kind_a_q <= LOC_KIND_RST[i];
        blk_a_q  <= LOC_BLK_RST[8*i +: 8];
        wrd_a_q  <= LOC_WRD_RST[8*i +: 8];
      end else begin
        if (wk && k_ok) begin
          kind_e_q <= reg_wdata_i[0];
        end
        if (wb && b_ok) begin
          blk_e_q <= reg_wdata_i;
        end
        if (ww) begin
          wrd_e_q <= reg_wdata_i;
        end
        if (run_rise) begin
          kind_a_q <= kind_e_q;
          blk_a_q  <= blk_e_q;
          wrd_a_q  <= wrd_e_q;
        end
      end
    end

    // for the coordination entries only, active kind also flags the high byte lane of a data word
    assign loc_e_rd[3*i]     = {7'h00, kind_e_q};
    assign loc_e_rd[3*i + 1] = blk_e_q;
    assign loc_e_rd[3*i + 2] = wrd_e_q;
    assign loc_a_rd[3*i]     = {6'h00, HI && kind_a_q, kind_a_q};
    assign loc_a_rd[3*i + 1] = blk_a_q;
    assign loc_a_rd[3*i + 2] = wrd_a_q;
  end

  // read selection
  wire [7:0] off_e = reg_addr_i - REG_LOC_EDIT;
  wire [7:0] off_a = reg_addr_i - REG_LOC_ACT;

  always_comb begin
    rd_val = 8'h00;
    if (reg_addr_i == REG_SCB) begin
      rd_val = {busy_q, 2'b00, expr_q, 3'b000, err_q};
    end else if (reg_addr_i == REG_RCB) begin
      rd_val = {rcb_permit_q, 2'b00, rcb_expr_q, 4'h0};
    end else if (reg_addr_i == REG_ISTAT) begin
      rd_val = {5'h00, istat_q};
    end else if (reg_addr_i == REG_IMASK) begin
      rd_val = {5'h00, imask_q};
    end else if (reg_addr_i == REG_STN_EDIT) begin
      rd_val = stn_edit_q;
    end else if (reg_addr_i == REG_PGN_EDIT) begin
      rd_val = pgn_edit_q;
    end else if (reg_addr_i == REG_STN_ACT) begin
      rd_val = stn_act_q;
    end else if (reg_addr_i == REG_PGN_ACT) begin
      rd_val = pgn_act_q;
    end else if (off_e < 8'h0c) begin
      rd_val = loc_e_rd[off_e[3:0]];
    end else if (off_a < 8'h0c) begin
      rd_val = loc_a_rd[off_a[3:0]];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_re_i ? rd_val : 8'h00;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign tx_valid_o   = tx_valid_q;
  assign tx_data_o    = tx_data_q;
  assign tx_last_o    = tx_last_q;
  assign tx_express_o = tx_expr_q;
  assign rx_wr_o      = rx_wr_q;
  assign rx_wr_idx_o  = rx_wr_idx_q;
  assign rx_wr_data_o = rx_wr_data_q;
  assign station_o    = stn_act_q;
  assign pgn_o        = pgn_act_q;
  assign irq_o        = irq_q;

  // checks on the handshake
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  busy_set_a: assert property (accept |=> busy_q && !err_q)
    else $error("accepted request did not set busy and clear error");
  busy_clr_a: assert property (done_evt |=> !busy_q)
    else $error("busy not cleared after send finished");
  err_fail_a: assert property (done_evt && tx_fail_i |=> err_q)
    else $error("failed send did not raise error");
  mbox_lock_a: assert property (busy_q |-> !mem_bus.we)
    else $error("mailbox written while busy");
  express_a: assert property (tx_valid_q |-> tx_expr_q == expr_q)
    else $error("express mark differs from requested");
  stn_range_a: assert property (stn_act_q >= STN_MIN && stn_act_q <= STN_MAX)
    else $error("station number out of range");
  rx_trunc_a: assert property (rx_wr_q |-> rx_wr_idx_q <= MBOX_LAST_IDX)
    else $error("receive write beyond mailbox end");
  param_hold_a: assert property (!$past(run_rise) |-> $stable(stn_act_q))
    else $error("active station changed without run transition");
  frame_end_a: assert property (hs && tx_last_q |-> ptr_q == last_idx)
    else $error("frame ended at wrong byte count");
  dest_ok_a: assert property (accept |-> dest_q <= DEST_MAX)
    else $error("request accepted with invalid destination");
  send_len_a: assert property (accept |-> ##3 (tx_valid_q && tx_data_q == len_q))
    else $error("length byte not offered three cycles after request");

  accept_c: cover property (accept);
  reject_c: cover property (reject);
  fail_c:   cover property (done_evt && tx_fail_i);
  trunc_c:  cover property (rx_valid_i && rcb_permit_q
                            && rx_idx_q == MBOX_FULL_IDX);
endmodule

// [verilog/nsm_pkg.sv]
// constants and types shared by the send mailbox handshake block
package nsm_pkg;
  // register map, byte addresses on the plain register port
  localparam logic [7:0] REG_SCB      = 8'h00;
  localparam logic [7:0] REG_RCB      = 8'h01;
  localparam logic [7:0] REG_ISTAT    = 8'h02;
  localparam logic [7:0] REG_IMASK    = 8'h03;
  localparam logic [7:0] REG_STN_EDIT = 8'h04;
  localparam logic [7:0] REG_PGN_EDIT = 8'h05;
  localparam logic [7:0] REG_STN_ACT  = 8'h06;
  localparam logic [7:0] REG_PGN_ACT  = 8'h07;
  localparam logic [7:0] REG_LOC_EDIT = 8'h08;
  localparam logic [7:0] REG_LOC_ACT  = 8'h20;
  localparam logic [7:0] REG_MBOX     = 8'h80;

  // send and receive coordination byte fields
  localparam int SCB_BUSY   = 7;
  localparam int SCB_EXPR   = 4;
  localparam int SCB_ERR    = 0;
  localparam int RCB_PERMIT = 7;
  localparam int RCB_EXPR   = 4;

  // interrupt status bits
  localparam int IRQ_W       = 3;
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_TX_ERR  = 1;
  localparam int IRQ_RX      = 2;

  // mailbox layout: length, destination, up to 64 payload bytes
  localparam int         MBOX_DEPTH    = 66;
  localparam logic [6:0] MBOX_LAST_IDX = 7'h41;
  localparam logic [6:0] MBOX_FULL_IDX = 7'h42;
  localparam logic [6:0] IDX_LEN       = 7'h00;
  localparam logic [6:0] IDX_DEST      = 7'h01;
  localparam logic [7:0] MAX_LEN       = 8'h40;
  localparam logic [7:0] DEST_MAX      = 8'h1f;

  // start-up parameters and their reset values
  localparam logic [7:0] STN_MIN = 8'h01;
  localparam logic [7:0] STN_MAX = 8'h1e;
  localparam logic [7:0] STN_RST = 8'h01;
  localparam logic [7:0] PGN_RST = 8'h01;
  localparam logic [7:0] BLK_MIN = 8'h02;

  // location entries: send box, receive box, send coord, receive coord
  localparam int          LOC_N        = 4;
  localparam int          LOC_SCB      = 2;
  localparam logic        KIND_FLAG    = 1'b0;
  localparam logic        KIND_DATA    = 1'b1;
  localparam logic [3:0]  LOC_KIND_RST = 4'h3;
  localparam logic [31:0] LOC_BLK_RST  = 32'h6465_0302;
  localparam logic [31:0] LOC_WRD_RST  = 32'h0000_0000;

  typedef logic [6:0] nsm_idx_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FETCH = 3'h1,
    ST_LOAD  = 3'h3,
    ST_HOLD  = 3'h2,
    ST_WAIT  = 3'h6
  } nsm_tx_state_t;
endpackage

// [verilog/nsm_mem_if.sv]
// interface between the handshake logic and its mailbox memory
`timescale 1ns/1ps
interface nsm_mem_if;
  logic       we;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic [6:0] raddr;
  logic [7:0] rdata;

  modport ctrl (output we, waddr, wdata, raddr, input rdata);
  modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface

// [verilog/nsm_mbox_mem.sv]
// send mailbox storage with registered read data
`timescale 1ns/1ps
module nsm_mbox_mem (
  input  wire logic clk_sys_i,
  nsm_mem_if.mem    mem_port
);
  import nsm_pkg::*;

  logic [7:0] store_q [MBOX_DEPTH];
  logic [7:0] rdata_q;

  // one write and one read port, read data one cycle after address
  always_ff @(posedge clk_sys_i) begin
    if (mem_port.we) begin
      store_q[mem_port.waddr] <= mem_port.wdata;
    end
    rdata_q <= store_q[mem_port.raddr];
  end

  assign mem_port.rdata = rdata_q;
endmodule

// [verif/nsm_link_model.sv]
// far-side link model: takes frame bytes, then reports completion
`timescale 1ns/1ps
module nsm_link_model (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       slow_i,
  input  wire logic       fail_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_last_i,
  input  wire logic       tx_express_i,
  output logic            tx_ready_o,
  output logic            tx_done_o,
  output logic            tx_fail_o
);
  logic [7:0] got [0:63];
  int         got_cnt;
  int         last_at;
  logic       got_expr;
  int         wait_cnt;

  // capture bytes, stall every other cycle when slow, pulse done later
  always @(posedge clk_sys_i) begin
    tx_done_o <= 1'b0;
    tx_fail_o <= 1'b0;
    tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
    if (sys_rst_i) begin
      tx_ready_o <= 1'b0;
      got_cnt <= 0;
      wait_cnt <= 0;
    end else begin
      if (tx_valid_i && tx_ready_o) begin
        got[got_cnt] <= tx_data_i;
        got_cnt <= got_cnt + 1;
        got_expr <= tx_express_i;
        if (tx_last_i) begin
          last_at <= got_cnt;
          wait_cnt <= 4;
        end
      end
      if (wait_cnt == 1) begin
        tx_done_o <= 1'b1;
        tx_fail_o <= fail_i;
      end
      if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

// [verif/tb_nsm_send_mailbox.sv]
// testbench for the send mailbox handshake block
`timescale 1ns/1ps
module tb_nsm_send_mailbox;
  import nsm_pkg::*;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } nsm_row_t;
  localparam nsm_row_t ROWS [0:24] = '{
    '{1'b0, REG_SCB, 8'h00, 8'h00}, '{1'b0, REG_STN_ACT, 8'h00, 8'h01},
    '{1'b0, REG_PGN_ACT, 8'h00, 8'h01}, '{1'b0, 8'h20, 8'h00, 8'h01},
    '{1'b0, 8'h21, 8'h00, 8'h02}, '{1'b0, 8'h22, 8'h00, 8'h00},
    '{1'b0, 8'h24, 8'h00, 8'h03}, '{1'b0, 8'h27, 8'h00, 8'h65},
    '{1'b0, 8'h2a, 8'h00, 8'h64}, '{1'b1, REG_STN_EDIT, 8'h1e, 8'h1e},
    '{1'b1, REG_STN_EDIT, 8'h1f, 8'h1e}, '{1'b1, REG_STN_EDIT, 8'h00, 8'h1e},
    '{1'b1, REG_PGN_EDIT, 8'h1f, 8'h01}, '{1'b1, REG_PGN_EDIT, 8'h05, 8'h05},
    '{1'b1, 8'h0e, 8'h01, 8'h01}, '{1'b1, 8'h0f, 8'h01, 8'h65},
    '{1'b1, 8'h10, 8'h07, 8'h07}, '{1'b1, 8'h7f, 8'h5a, 8'h00},
    '{1'b1, REG_MBOX, 8'h03, 8'h00}, '{1'b0, REG_STN_ACT, 8'h00, 8'h01},
    '{1'b0, REG_STN_ACT, 8'h00, 8'h1e}, '{1'b0, REG_PGN_ACT, 8'h00, 8'h05},
    '{1'b0, 8'h26, 8'h00, 8'h03}, '{1'b0, 8'h27, 8'h00, 8'h65},
    '{1'b0, 8'h28, 8'h00, 8'h07}};
  logic       clk_sys, sys_rst, reg_we, reg_re, run, slow, fail;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data, rx_data;
  logic       tx_valid, tx_last, tx_express, tx_ready, tx_done, tx_fail;
  logic       rx_valid, rx_last, rx_express, rx_wr, irq;
  logic [7:0] rx_wr_data, station, programmer_bus_number;
  nsm_idx_t   rx_wr_idx, rx_max;
  int         bad_count, num_checks, rx_cnt, n;

  nsm_send_mailbox u_nsm_send_mailbox (
    .clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
    .reg_rdata_o(reg_rdata), .run_i(run), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .tx_last_o(tx_last), .tx_express_o(tx_express),
    .tx_ready_i(tx_ready), .tx_done_i(tx_done), .tx_fail_i(tx_fail),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_last_i(rx_last),
    .rx_express_i(rx_express), .rx_wr_o(rx_wr), .rx_wr_idx_o(rx_wr_idx),
    .rx_wr_data_o(rx_wr_data), .station_o(station), .pgn_o(programmer_bus_number),
    .irq_o(irq));
  nsm_link_model u_nsm_link_model (
    .clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .slow_i(slow),
    .fail_i(fail), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_last_i(tx_last), .tx_express_i(tx_express), .tx_ready_o(tx_ready),
    .tx_done_o(tx_done), .tx_fail_o(tx_fail));

  // clock generator
  always #4 clk_sys = ~clk_sys;

  task automatic close_out;
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // poll busy under a bound, then the error bit means something
  task automatic wait_idle;
    logic [7:0] v;
    v = 8'h80;
    for (n = 0; n < 100 && v[7] !== 1'b0; n++) begin
      @(posedge clk_sys);
      reg_addr <= REG_SCB;
      reg_re <= 1'b1;
      @(posedge clk_sys);
      reg_re <= 1'b0;
      #1;
      v = reg_rdata;
    end
    num_checks++;
    if (v[7] !== 1'b0) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, v, 8'h00);
      close_out();
    end
  endtask
  task automatic fill(input logic [7:0] len, input logic [7:0] dst);
    wr(REG_MBOX, len);
    wr(REG_MBOX + 8'h01, dst);
    for (int i = 0; i < len; i++) wr(REG_MBOX + 8'h02 + 8'(i), 8'ha0 + 8'(i));
  endtask
  // request a frame, disturb the locked mailbox, then check the link bytes
  task automatic send(input logic [7:0] ctl, input logic [7:0] len,
                      input logic [7:0] dst, input logic f);
    int b;
    b = u_nsm_link_model.got_cnt;
    wr(REG_SCB, ctl);
    rchk(REG_SCB, ctl);
    wr(REG_MBOX + 8'h02, 8'hee);
    wait_idle();
    chk(8'(u_nsm_link_model.got_cnt - b), len + 8'h02);
    chk(8'(u_nsm_link_model.last_at - b), len + 8'h01);
    chk(u_nsm_link_model.got[b], len);
    chk(u_nsm_link_model.got[b + 1], dst);
    for (int i = 0; i < len; i++)
      chk(u_nsm_link_model.got[b + 2 + i], 8'ha0 + 8'(i));
    chk({7'h00, u_nsm_link_model.got_expr}, {7'h00, ctl[4]});
    rchk(REG_SCB, {3'b000, ctl[4], 3'b000, f});
  endtask
  task automatic rx_frame(input int cnt, input logic ex);
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_data <= 8'(i);
      rx_last <= (i == cnt - 1);
      rx_express <= ex;
    end
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask

  // receive mailbox write monitor
  always @(posedge clk_sys) begin
    if (rx_wr === 1'b1) begin
      rx_cnt <= rx_cnt + 1;
      if (rx_wr_idx > rx_max) rx_max <= rx_wr_idx;
      chk(rx_wr_data, {1'b0, rx_wr_idx});
    end
  end

  // main sequence
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {reg_we, reg_re, run, slow, fail} = 5'h00;
    {rx_valid, rx_last, rx_express} = 3'h0;
    {reg_addr, reg_wdata, rx_data} = 24'h00_0000;
    {bad_count, num_checks, rx_cnt, rx_max} = '0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      if (ROWS[i].wr) wr(ROWS[i].addr, ROWS[i].wdata);
      rchk(ROWS[i].addr, ROWS[i].exp);
    end
    @(posedge clk_sys);
    run <= 1'b1;
    for (n = 0; n < 20 && station !== 8'h1e; n++) @(posedge clk_sys);
    chk(station, 8'h1e);
    chk(programmer_bus_number, 8'h05);
    for (int i = 20; i < 25; i++) begin
      rchk(ROWS[i].addr, ROWS[i].exp);
    end
    slow <= 1'b1;
    fill(8'h03, 8'h1f);
    send(8'h90, 8'h03, 8'h1f, 1'b0);
    rchk(REG_ISTAT, 8'h01);
    rchk(REG_ISTAT, 8'h00);
    slow <= 1'b0;
    fail <= 1'b1;
    wr(REG_IMASK, 8'h03);
    fill(8'h00, 8'h00);
    send(8'h80, 8'h00, 8'h00, 1'b1);
    chk({7'h00, irq}, 8'h01);
    rchk(REG_ISTAT, 8'h03);
    repeat (2) @(posedge clk_sys);
    chk({7'h00, irq}, 8'h00);
    fail <= 1'b0;
    send(8'h80, 8'h00, 8'h00, 1'b0);
    rchk(REG_ISTAT, 8'h01);
    // requests with a bad length or destination are refused with error
    wr(REG_MBOX, 8'h41);
    wr(REG_SCB, 8'h80);
    rchk(REG_SCB, 8'h01);
    wr(REG_MBOX, 8'h00);
    wr(REG_MBOX + 8'h01, 8'h20);
    wr(REG_SCB, 8'h80);
    rchk(REG_SCB, 8'h01);
    rchk(REG_ISTAT, 8'h02);
    wr(REG_RCB, 8'h80);
    rx_frame(68, 1'b1);
    repeat (3) @(posedge clk_sys);
    chk(8'(rx_cnt), 8'h42);
    chk({1'b0, rx_max}, 8'h41);
    rchk(REG_RCB, 8'h10);
    rchk(REG_ISTAT, 8'h04);
    rx_frame(2, 1'b0);
    repeat (3) @(posedge clk_sys);
    chk(8'(rx_cnt), 8'h42);
    close_out();
  end
endmodule
